/* fp_alu_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Datapath stand-in
// ****************************************************************
module fp_alu_model
  import fp_ctx_pkg::*;
(
  input  wire logic [63:0] srcA,
  input  wire logic [63:0] srcB,
  input  wire logic [7:0]  excCmd,
  input  wire logic [1:0]  cmpCmd,
  output logic      [63:0] result,
  output logic      [7:0]  excOut,
  output logic      [1:0]  cmpOut
);
  // Word-wise sum, so a wrong operand choice shows in the result
  assign result = {srcA[63:32] + srcB[63:32], srcA[31:0] + srcB[31:0]};
  // Exceptions and compare outcomes appear only when the bench commands them
  assign excOut = excCmd;
  assign cmpOut = cmpCmd;
endmodule : fp_alu_model

/* fp_context_reg.sv */
`timescale 1ns/1ps
module fp_context_reg
  import fp_ctx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ctxWrite,
  input  wire logic [31:0] ctxData,
  input  wire logic        endValid,
  input  wire logic [7:0]  endExc,
  input  wire logic        cmpValid,
  input  wire logic [1:0]  cmpCode,
  output logic      [31:0] processContext,
  output logic             trapHit
);

  logic [7:0] liveExc;
  logic [7:0] cmpByte;

  // The data chain exception is never raised by this device
  assign liveExc = endValid ? (endExc & ~(8'h01 << EXC_DATA_CHAIN)) : 8'h00;

  always_comb
  begin
    cmpByte = 8'h00;
    case (cmpCode)
      CMP_EQ:    cmpByte[CMP_ZERO_BIT] = 1'b1;
      CMP_LT:    cmpByte[CMP_LESS_BIT] = 1'b1;
      CMP_GT:    cmpByte = 8'h00;
      default:
      begin
        cmpByte[CMP_ZERO_BIT]  = 1'b1;
        cmpByte[CMP_UNORD_BIT] = 1'b1;
        cmpByte[CMP_LESS_BIT]  = 1'b1;
      end
    endcase
  end

  // Checked against the mask in force before any load in the same cycle
  assign trapHit = |(liveExc & ~processContext[TRAP_MSB:TRAP_LSB]);

  // ****************************************************************
  // Field updates
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      processContext[UPD_MSB:UPD_LSB] <= CTX_RESET[UPD_MSB:UPD_LSB];
    else if (ctxWrite)
      processContext[UPD_MSB:UPD_LSB] <= ctxData[UPD_MSB:UPD_LSB];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      processContext[RND_MSB:RND_LSB] <= CTX_RESET[RND_MSB:RND_LSB];
    else if (ctxWrite && ctxData[UPD_MSB:UPD_LSB] == UPD_FULL)
      processContext[RND_MSB:RND_LSB] <= ctxData[RND_MSB:RND_LSB];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      processContext[TRAP_MSB:TRAP_LSB] <= CTX_RESET[TRAP_MSB:TRAP_LSB];
    else if (ctxWrite)
      processContext[TRAP_MSB:TRAP_LSB] <= ctxData[TRAP_MSB:TRAP_LSB];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      processContext[CMP_MSB:CMP_LSB] <= CTX_RESET[CMP_MSB:CMP_LSB];
    else if (cmpValid)
      processContext[CMP_MSB:CMP_LSB] <= cmpByte;
    else if (ctxWrite)
      processContext[CMP_MSB:CMP_LSB] <= ctxData[CMP_MSB:CMP_LSB];
  end

  // A load writes the flags from the loaded data, but an exception in the same cycle still sticks
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      processContext[STICKY_MSB:STICKY_LSB] <= CTX_RESET[STICKY_MSB:STICKY_LSB];
    else if (ctxWrite)
      processContext[STICKY_MSB:STICKY_LSB] <= ctxData[STICKY_MSB:STICKY_LSB] | liveExc;
    else
      processContext[STICKY_MSB:STICKY_LSB] <=
        processContext[STICKY_MSB:STICKY_LSB] | liveExc;
  end

endmodule : fp_context_reg

/* fp_ctx_pkg.sv */
package fp_ctx_pkg;

  // ****************************************************************
  // Context register field layout
  // ****************************************************************
  localparam int UPD_MSB    = 31;
  localparam int UPD_LSB    = 28;
  localparam int RND_MSB    = 27;
  localparam int RND_LSB    = 24;
  localparam int TRAP_MSB   = 23;
  localparam int TRAP_LSB   = 16;
  localparam int CMP_MSB    = 15;
  localparam int CMP_LSB    = 8;
  localparam int STICKY_MSB = 7;
  localparam int STICKY_LSB = 0;

  // Bits inside the rounding control field
  localparam int RND_MODE_MSB = 27;
  localparam int RND_MODE_LSB = 26;
  localparam int RND_CONV_BIT = 25;
  localparam int RND_FAST_BIT = 24;

  // Exception positions within the trap enable and sticky flag bytes
  localparam int EXC_DATA_CHAIN = 7;
  localparam int EXC_BAD_OPCODE = 6;
  localparam int EXC_INEXACT    = 5;
  localparam int EXC_UNDERFLOW  = 4;
  localparam int EXC_OVERFLOW   = 3;
  localparam int EXC_DIV_ZERO   = 2;
  localparam int EXC_INVALID    = 0;

  // Compare result bits within the compare result byte
  localparam int CMP_ZERO_BIT  = 6;
  localparam int CMP_UNORD_BIT = 2;
  localparam int CMP_LESS_BIT  = 0;

  localparam logic [3:0]  UPD_PARTIAL = 4'hC;
  localparam logic [3:0]  UPD_FULL    = 4'h0;
  localparam logic [31:0] CTX_RESET   = 32'h0100_0000;

  localparam logic [1:0] ROUND_NEAREST   = 2'h0;
  localparam logic [1:0] ROUND_TOWARD_ZERO = 2'h1;
  localparam logic [1:0] ROUND_PLUS_INF  = 2'h2;
  localparam logic [1:0] ROUND_MINUS_INF = 2'h3;

  // ****************************************************************
  // Instruction and operand codes
  // ****************************************************************
  localparam logic [3:0] OP_MOVE_REG  = 4'h1;
  localparam logic [3:0] OP_LOAD      = 4'h2;
  localparam logic [3:0] OP_STORE     = 4'h3;
  localparam logic [3:0] OP_LOAD_CTX  = 4'h4;
  localparam logic [3:0] OP_STORE_CTX = 4'h5;
  localparam logic [3:0] OP_ARITH     = 4'h6;
  localparam logic [3:0] OP_COMPARE   = 4'h7;

  localparam logic [1:0] SRC_REG  = 2'h0;
  localparam logic [1:0] SRC_IMM  = 2'h1;
  localparam logic [1:0] SRC_HOST = 2'h2;

  localparam logic [1:0] CMP_EQ    = 2'h0;
  localparam logic [1:0] CMP_LT    = 2'h1;
  localparam logic [1:0] CMP_GT    = 2'h2;
  localparam logic [1:0] CMP_UNORD = 2'h3;

  localparam int REG_COUNT = 32;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } seq_state_type;

endpackage : fp_ctx_pkg

/* fp_reg_bank.sv */
`timescale 1ns/1ps
module fp_reg_bank
  import fp_ctx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wrEn,
  input  wire logic        wrDouble,
  input  wire logic [4:0]  wrIdx,
  input  wire logic [63:0] wrData,
  input  wire logic [4:0]  rdAIdx,
  input  wire logic        rdADouble,
  output logic      [63:0] rdAData,
  input  wire logic [4:0]  rdBIdx,
  input  wire logic        rdBDouble,
  output logic      [63:0] rdBData
);

  logic [31:0] singleReg [REG_COUNT];
  logic [4:0]  evenIdx;

  // A pair is always named by its even register; bit 0 is ignored
  assign evenIdx = {wrIdx[4:1], 1'b0};

  // ****************************************************************
  // Storage
  // ****************************************************************
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_reg
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
        singleReg[i] <= 32'h0000_0000;
      else if (wrEn && !wrDouble && wrIdx == 5'(i))
        singleReg[i] <= wrData[31:0];
      else if (wrEn && wrDouble && evenIdx == 5'(i))
        singleReg[i] <= wrData[63:32];
      else if (wrEn && wrDouble && evenIdx == 5'(i - 1))
        singleReg[i] <= wrData[31:0];
    end
  end

  // Singles sit in the low word; a pair returns even word on top
  assign rdAData = rdADouble
    ? {singleReg[{rdAIdx[4:1], 1'b0}], singleReg[{rdAIdx[4:1], 1'b1}]}
    : {32'h0000_0000, singleReg[rdAIdx]};
  assign rdBData = rdBDouble
    ? {singleReg[{rdBIdx[4:1], 1'b0}], singleReg[{rdBIdx[4:1], 1'b1}]}
    : {32'h0000_0000, singleReg[rdBIdx]};

endmodule : fp_reg_bank

/* fp_regfile_context.sv */
// Contract
// - thirty-two single registers, each addressable as an operand
// - even-numbered pairs act as sixteen double registers
// - double pair holds high word in even, low word in odd register
// - 32-bit context register, writable for control, readable for status
// - fields: select 31-28, rounding 27-24, traps 23-16, compare 15-8, flags 7-0
// - select 1100 loads traps, compare and flags but keeps rounding
// - select 0000 loads traps, compare, flags and rounding
// - two rounding bits choose nearest, zero, plus or minus infinity
// - third rounding bit makes conversions use current mode or truncate
// - flag byte holds the five standard flags plus device flags
// - writing zeros into flag bits clears those flags
// - at instruction end flags OR in exception status, regardless of masks
// - trap enable byte positions 23, 22, 21, 20, 19, 18 and 16
// - an exception with its mask bit low raises the interrupt request
// - an unrecognised broadcast instruction flags the bad opcode exception
// - the data chain exception flag is never set
// - compare byte changes only on test or compare instructions; context loads also write it
// - compare codes in bits 14, 10, 8: equal 100, less 001, greater 000, unordered 111
// - result goes to second source; first is register, immediate or host data
// - data moves host to register, register to host, and register to register
`timescale 1ns/1ps
module fp_regfile_context
  import fp_ctx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        instrValid,
  output logic             instrReady,
  input  wire logic [3:0]  instrOp,
  input  wire logic        instrDouble,
  input  wire logic [4:0]  src2Idx,
  input  wire logic [4:0]  src1Idx,
  input  wire logic [1:0]  src1Kind,
  input  wire logic [31:0] hostData,
  input  wire logic [31:0] immData,
  output logic      [63:0] operandSrc1,
  output logic      [63:0] operandSrc2,
  input  wire logic [63:0] aluResult,
  input  wire logic [7:0]  aluExc,
  input  wire logic [1:0]  aluCmp,
  output logic             readValid,
  output logic      [31:0] readData,
  output logic             intReq,
  output logic      [1:0]  roundMode,
  output logic             convTruncate,
  output logic             fastMode
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  seq_state_type state;
  seq_state_type next_state;
  logic          accept;
  logic          knownOp;
  logic          isArith;
  logic          isCompare;
  logic          isCtxLoad;
  logic          isRead;
  logic          wrEn;
  logic [63:0]   wrData;
  logic [4:0]    rdAIdx;
  logic [63:0]   rdAData;
  logic [63:0]   rdBData;
  logic [63:0]   src1Value;
  logic [7:0]    endExc;
  logic [31:0]   processContext;
  logic          trapHit;

  assign accept     = instrValid && instrReady;
  assign instrReady = (state == ST_IDLE);
  assign readValid  = (state == ST_WAIT);

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  assign knownOp = (instrOp == OP_MOVE_REG) || (instrOp == OP_LOAD) ||
                   (instrOp == OP_STORE) || (instrOp == OP_LOAD_CTX) ||
                   (instrOp == OP_STORE_CTX) || (instrOp == OP_ARITH) ||
                   (instrOp == OP_COMPARE);
  assign isArith   = accept && instrOp == OP_ARITH;
  assign isCompare = accept && instrOp == OP_COMPARE;
  assign isCtxLoad = accept && instrOp == OP_LOAD_CTX;
  assign isRead    = accept && (instrOp == OP_STORE || instrOp == OP_STORE_CTX);

  // Only arithmetic and compare pass on datapath exceptions
  always_comb
  begin
    endExc = 8'h00;
    if (!knownOp)
      endExc[EXC_BAD_OPCODE] = 1'b1;
    else if (instrOp == OP_ARITH || instrOp == OP_COMPARE)
      endExc = aluExc;
  end

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  // Store reads the second-source register; moves read the first source
  assign rdAIdx = (instrOp == OP_STORE) ? src2Idx : src1Idx;

  always_comb
  begin
    if (src1Kind == SRC_IMM)
      src1Value = instrDouble ? {immData, 32'h0000_0000} : {32'h0000_0000, immData};
    else if (src1Kind == SRC_HOST)
      src1Value = instrDouble ? {hostData, 32'h0000_0000} : {32'h0000_0000, hostData};
    else
      src1Value = rdAData;
  end

  assign operandSrc1 = src1Value;
  assign operandSrc2 = rdBData;

  // Results always land in the second-source register
  assign wrEn = accept && (instrOp == OP_MOVE_REG || instrOp == OP_LOAD ||
                           instrOp == OP_ARITH);
  assign wrData = (instrOp == OP_ARITH) ? aluResult : src1Value;

  fp_reg_bank u_bank
  (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .wrEn      (wrEn),
    .wrDouble  (instrDouble),
    .wrIdx     (src2Idx),
    .wrData    (wrData),
    .rdAIdx    (rdAIdx),
    .rdADouble (instrDouble),
    .rdAData   (rdAData),
    .rdBIdx    (src2Idx),
    .rdBDouble (instrDouble),
    .rdBData   (rdBData)
  );

  fp_context_reg u_ctx
  (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .ctxWrite       (isCtxLoad),
    .ctxData        (hostData),
    .endValid       (accept),
    .endExc         (endExc),
    .cmpValid       (isCompare),
    .cmpCode        (aluCmp),
    .processContext (processContext),
    .trapHit        (trapHit)
  );

  // ****************************************************************
  // Read sequencing: one wait state before data is valid
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (isRead) next_state = ST_WAIT;
      ST_WAIT: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      readData <= 32'h0000_0000;
    else if (isRead && instrOp == OP_STORE_CTX)
      readData <= processContext;
    else if (isRead)
      readData <= instrDouble ? rdAData[63:32] : rdAData[31:0];
  end

  // Held until the next context load so the host sees a level
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      intReq <= 1'b0;
    else if (trapHit)
      intReq <= 1'b1;
    else if (isCtxLoad)
      intReq <= 1'b0;
  end

  // ****************************************************************
  // Rounding control outputs
  // ****************************************************************
  assign roundMode    = processContext[RND_MODE_MSB:RND_MODE_LSB];
  assign convTruncate = processContext[RND_CONV_BIT];
  assign fastMode     = processContext[RND_FAST_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  partial_keeps_round_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCtxLoad && hostData[UPD_MSB:UPD_LSB] == UPD_PARTIAL
    |=> $stable(processContext[RND_MSB:RND_LSB]))
    else $error("rounding field changed on partial load");

  full_loads_round_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCtxLoad && hostData[UPD_MSB:UPD_LSB] == UPD_FULL
    |=> processContext[RND_MSB:RND_LSB] == $past(hostData[RND_MSB:RND_LSB]))
    else $error("rounding field not loaded on full load");

  sticky_or_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && !isCtxLoad
    |=> processContext[STICKY_MSB:STICKY_LSB] ==
        ($past(processContext[STICKY_MSB:STICKY_LSB]) |
         ($past(endExc) & ~(8'h01 << EXC_DATA_CHAIN))))
    else $error("sticky flags did not accumulate");

  flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCtxLoad && hostData[STICKY_MSB:STICKY_LSB] == 8'h00 && endExc == 8'h00
    |=> processContext[STICKY_MSB:STICKY_LSB] == 8'h00)
    else $error("flags not cleared by zero load");

  no_chain_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    !processContext[EXC_DATA_CHAIN] |=> !processContext[EXC_DATA_CHAIN] || $past(isCtxLoad))
    else $error("data chain flag set by hardware");

  bad_opcode_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && !knownOp |=> processContext[EXC_BAD_OPCODE])
    else $error("bad opcode flag missing");

  cmp_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !isCompare && !isCtxLoad |=> $stable(processContext[CMP_MSB:CMP_LSB]))
    else $error("compare byte changed without compare");

  cmp_equal_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCompare && aluCmp == CMP_EQ
    |=> processContext[CMP_LSB + CMP_ZERO_BIT] && !processContext[CMP_LSB + CMP_UNORD_BIT]
        && !processContext[CMP_LSB + CMP_LESS_BIT])
    else $error("equal compare code wrong");

  trap_raise_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && |(endExc & ~(8'h01 << EXC_DATA_CHAIN) & ~processContext[TRAP_MSB:TRAP_LSB])
    |=> intReq)
    else $error("unmasked exception did not interrupt");

  masked_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    !intReq && (!accept || (endExc & ~processContext[TRAP_MSB:TRAP_LSB]) == 8'h00)
    |=> !intReq)
    else $error("interrupt without unmasked exception");

  read_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    isRead && instrOp == OP_STORE_CTX
    |=> readValid && readData == $past(processContext) ##1 !readValid)
    else $error("context read data or timing wrong");

  pair_store_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && instrOp == OP_LOAD && instrDouble && src1Kind == SRC_HOST
    ##1 accept && instrOp == OP_STORE && !instrDouble
        && src2Idx == {$past(src2Idx[4:1]), 1'b0}
    |=> readData == $past(hostData, 2))
    else $error("double high word not in even register");

  cmp_less_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCompare && aluCmp == CMP_LT
    |=> processContext[CMP_MSB:CMP_LSB] == 8'h01)
    else $error("less compare code wrong");

  cmp_unord_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCompare && aluCmp == CMP_UNORD
    |=> processContext[CMP_MSB:CMP_LSB] == 8'h45)
    else $error("unordered compare code wrong");

  cmp_greater_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCompare && aluCmp == CMP_GT
    |=> processContext[CMP_MSB:CMP_LSB] == 8'h00)
    else $error("greater compare code wrong");

  trap_load_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCtxLoad
    |=> processContext[TRAP_MSB:TRAP_LSB] == $past(hostData[TRAP_MSB:TRAP_LSB]))
    else $error("trap enable byte not loaded");

  store_reg_a: assert property (@(posedge sys_clk) disable iff (rst)
    isRead && instrOp == OP_STORE && !instrDouble
    |=> readValid && readData == $past(operandSrc2[31:0]))
    else $error("register store data or timing wrong");

  single_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && instrOp == OP_LOAD && !instrDouble && src1Kind == SRC_HOST
    |=> !$stable(src2Idx) || instrDouble || operandSrc2[31:0] == $past(hostData))
    else $error("single register load did not land");

  pair_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    accept && instrOp == OP_LOAD && instrDouble && src1Kind == SRC_HOST
    |=> !$stable(src2Idx[4:1]) || !instrDouble
        || operandSrc2 == {$past(hostData), 32'h0000_0000})
    else $error("double load halves misplaced");

  int_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    isCtxLoad && !trapHit
    |=> !intReq)
    else $error("interrupt not cleared by context load");

endmodule : fp_regfile_context

/* fp_regfile_context_tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module fp_regfile_context_tb_top
  import fp_ctx_pkg::*;
;
  logic        sys_clk, rst, instrValid, instrReady, instrDouble, readValid;
  logic        intReq, convTruncate, fastMode;
  logic [3:0]  instrOp;
  logic [4:0]  src2Idx, src1Idx;
  logic [1:0]  src1Kind, aluCmp, cmpCmd, roundMode;
  logic [31:0] hostData, immData, readData;
  logic [63:0] operandSrc1, operandSrc2, aluResult, pv;
  logic [7:0]  aluExc, excCmd;
  logic [31:0] r;
  int          err_total, check_count, cycles;

  fp_regfile_context u_fp_regfile_context (.sys_clk(sys_clk), .rst(rst),
    .instrValid(instrValid), .instrReady(instrReady), .instrOp(instrOp),
    .instrDouble(instrDouble), .src2Idx(src2Idx), .src1Idx(src1Idx),
    .src1Kind(src1Kind), .hostData(hostData), .immData(immData),
    .operandSrc1(operandSrc1), .operandSrc2(operandSrc2), .aluResult(aluResult),
    .aluExc(aluExc), .aluCmp(aluCmp), .readValid(readValid), .readData(readData),
    .intReq(intReq), .roundMode(roundMode), .convTruncate(convTruncate),
    .fastMode(fastMode));
  fp_alu_model u_fp_alu_model (.srcA(operandSrc1), .srcB(operandSrc2),
    .excCmd(excCmd), .cmpCmd(cmpCmd), .result(aluResult), .excOut(aluExc),
    .cmpOut(aluCmp));

  always #4 sys_clk = ~sys_clk;

  // Hang guard: the whole sequence needs under a hundred cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      test_done();
    end
  end

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic issue(input logic [3:0] op, input logic dbl, input logic [4:0] s2,
                       input logic [4:0] s1, input logic [1:0] k, input logic [31:0] d);
    @(negedge sys_clk);
    instrValid  = 1'b1;
    instrOp     = op;
    instrDouble = dbl;
    src2Idx     = s2;
    src1Idx     = s1;
    src1Kind    = k;
    // The unused source carries the inverse so a wrong pick is visible
    hostData    = (k == SRC_IMM) ? ~d : d;
    immData     = (k == SRC_IMM) ? d : ~d;
    while (instrReady !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    instrValid  = 1'b0;
  endtask : issue

  task automatic ctx_read(output logic [31:0] v);
    issue(OP_STORE_CTX, 1'b0, 5'h01, 5'h01, SRC_REG, 32'h0);
    `CHK(readValid, 1'b1)
    `CHK(instrReady, 1'b0)
    v = readData;
  endtask : ctx_read

  task automatic ctx_write(input logic [31:0] v);
    issue(OP_LOAD_CTX, 1'b0, 5'h01, 5'h01, SRC_HOST, v);
  endtask : ctx_write

  task automatic peek(input logic [4:0] idx, input logic dbl);
    @(negedge sys_clk);
    src2Idx     = idx;
    instrDouble = dbl;
    #1 pv = operandSrc2;
  endtask : peek

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    ctx_read(r);
    `CHK(r, CTX_RESET)
    `CHK(intReq, 1'b0)
    `CHK(roundMode, ROUND_NEAREST)
  endtask : test_reset

  task automatic test_round;
    logic [1:0]  m;
    logic [31:0] v;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      // Fast bit always written as one, compare bit 13 as zero
      v = {UPD_FULL, m, m[0], 1'b1, 24'hFF4000};
      ctx_write(v);
      `CHK(roundMode, m)
      `CHK(convTruncate, m[0])
      `CHK(fastMode, 1'b1)
      ctx_read(r);
      `CHK(r, v)
    end
  endtask : test_round

  task automatic test_partial;
    ctx_write({UPD_FULL, 4'hB, 24'hFF0000});
    ctx_write({UPD_PARTIAL, 4'h5, 24'hFF0124});
    ctx_read(r);
    `CHK(r, {UPD_PARTIAL, 4'hB, 24'hFF0124})
    `CHK(roundMode, 2'h2)
    ctx_write({UPD_PARTIAL, 4'h1, 24'hFF0000});
    ctx_read(r);
    `CHK(r[7:0], 8'h00)
  endtask : test_partial

  task automatic test_moves;
    // Register zero is left alone as a general operand
    issue(OP_LOAD, 1'b0, 5'h05, 5'h00, SRC_HOST, 32'h1234_5678);
    peek(5'h05, 1'b0);
    `CHK(pv[31:0], 32'h1234_5678)
    issue(OP_LOAD, 1'b0, 5'h1F, 5'h00, SRC_IMM, 32'h0BAD_F00D);
    peek(5'h1F, 1'b0);
    `CHK(pv[31:0], 32'h0BAD_F00D)
    issue(OP_MOVE_REG, 1'b0, 5'h07, 5'h1F, SRC_REG, 32'h0);
    peek(5'h07, 1'b0);
    `CHK(pv[31:0], 32'h0BAD_F00D)
    issue(OP_LOAD, 1'b1, 5'h08, 5'h00, SRC_HOST, 32'hCAFE_0001);
    peek(5'h08, 1'b1);
    `CHK(pv, 64'hCAFE_0001_0000_0000)
    issue(OP_LOAD, 1'b0, 5'h09, 5'h00, SRC_HOST, 32'h0000_ABCD);
    issue(OP_MOVE_REG, 1'b1, 5'h0A, 5'h08, SRC_REG, 32'h0);
    peek(5'h0A, 1'b1);
    `CHK(pv, 64'hCAFE_0001_0000_ABCD)
    issue(OP_STORE, 1'b0, 5'h05, 5'h05, SRC_REG, 32'h0);
    `CHK(readValid, 1'b1)
    `CHK(readData, 32'h1234_5678)
  endtask : test_moves

  task automatic test_arith;
    // Only the divide-by-zero trap is enabled
    ctx_write({UPD_PARTIAL, 4'h1, 24'hFB0000});
    excCmd = 8'h20;
    issue(OP_ARITH, 1'b0, 5'h05, 5'h07, SRC_REG, 32'h0);
    `CHK(intReq, 1'b0)
    peek(5'h05, 1'b0);
    `CHK(pv[31:0], 32'h1DE2_4685)
    excCmd = 8'h04;
    issue(OP_ARITH, 1'b0, 5'h05, 5'h07, SRC_REG, 32'h0);
    `CHK(intReq, 1'b1)
    excCmd = 8'h80;
    issue(OP_ARITH, 1'b0, 5'h05, 5'h07, SRC_REG, 32'h0);
    excCmd = 8'h00;
    ctx_read(r);
    `CHK(r[7:0], 8'h24)
    `CHK(r[15:8], 8'h00)
    ctx_write({UPD_PARTIAL, 4'h1, 24'hBF0000});
    `CHK(intReq, 1'b0)
    issue(4'hF, 1'b0, 5'h05, 5'h07, SRC_REG, 32'h0);
    `CHK(intReq, 1'b1)
    ctx_read(r);
    `CHK(r[7:0], 8'h40)
    ctx_write({UPD_PARTIAL, 4'h1, 24'hFF0000});
  endtask : test_arith

  task automatic test_compare;
    logic [1:0] code [4] = '{CMP_EQ, CMP_GT, CMP_UNORD, CMP_LT};
    logic [7:0] want [4] = '{8'h40, 8'h00, 8'h45, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      cmpCmd = code[i];
      issue(OP_COMPARE, 1'b0, 5'h05, 5'h07, SRC_REG, 32'h0);
      ctx_read(r);
      `CHK(r[15:8], want[i])
    end
    issue(OP_ARITH, 1'b0, 5'h06, 5'h07, SRC_REG, 32'h0);
    ctx_read(r);
    `CHK(r[15:8], 8'h01)
  endtask : test_compare

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    {sys_clk, instrValid, instrOp, instrDouble, src2Idx, src1Idx} = '0;
    {src1Kind, hostData, immData, excCmd, cmpCmd} = '0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    test_reset();
    test_round();
    test_partial();
    test_moves();
    test_arith();
    test_compare();
    test_done();
  end
endmodule : fp_regfile_context_tb_top
